// *** src/rfa_regs.vh ***
// register offsets, field positions, reset values and access codes for the policy bank
`ifndef RFA_REGS_VH
`define RFA_REGS_VH
// register byte offsets from the module base
`define RFA_OFF_CTRL 12'h000
`define RFA_OFF_STAT 12'h004
`define RFA_OFF_RWC 12'h008
`define RFA_OFF_ISR 12'h00c
`define RFA_OFF_ICLR 12'h010
`define RFA_OFF_SET 12'h014
`define RFA_OFF_ID 12'h018
`define RFA_OFF_EVT 12'h01c
// live field of each register but ICLR, which reuses the ISR mask; everything above reads zero
`define RFA_CTRL_MASK 32'h0000ffff
`define RFA_STAT_MASK 32'h000000ff
`define RFA_RWC_MASK 32'h0000ffff
`define RFA_ISR_MASK 32'h000000ff
`define RFA_SET_MASK 32'h000000ff
`define RFA_ID_MASK 32'h0000ffff
`define RFA_EVT_MASK 32'h000000ff
// reset values
`define RFA_CTRL_RST 32'h00000000
`define RFA_ID_VAL 32'h00005a5a
// module base address
`define RFA_BASE 32'h40000000
// access policy codes
`define RFA_POL_RO 3'h0
`define RFA_POL_RW 3'h1
`define RFA_POL_RC 3'h2
`define RFA_POL_RWC 3'h3
`define RFA_POL_RW1C 3'h4
`define RFA_POL_W1C 3'h5
`define RFA_POL_RW1S 3'h6
`define RFA_POL_NONE 3'h7
`endif

// *** src/rfa_field.v ***
// one register cell applying a selectable software access policy
`timescale 1ns/1ps
module rfa_field #(
    parameter [2:0] POLICY = 3'h1,
    parameter [31:0] MASK = 32'h0000ffff,
    parameter [31:0] RESET_VAL = 32'h00000000
) (
    input wire clk,
    input wire resetn,
    input wire wrEn,
    input wire rdEn,
    input wire [31:0] wrData,
    input wire [31:0] hwSet,
    output wire [31:0] value
);
`include "rfa_regs.vh"
    reg [31:0] val_r;
    reg [31:0] val_nxt;
    assign value = val_r;
    // next value: hardware sets always win over any software clear
    always @* begin
        val_nxt = val_r;
        case (POLICY)
            `RFA_POL_RW: if (wrEn) val_nxt = wrData; // R11
            `RFA_POL_RC: if (rdEn) val_nxt = 32'h00000000; // R01
            `RFA_POL_RWC: if (wrEn) val_nxt = 32'h00000000; // R03
            `RFA_POL_RW1C: if (wrEn) val_nxt = val_r & ~wrData; // R04 R05
            `RFA_POL_W1C: if (wrEn) val_nxt = val_r & ~wrData; // R06
            `RFA_POL_RW1S: if (wrEn) val_nxt = val_r | wrData; // R07
            default: val_nxt = val_r;
        endcase
        val_nxt = (val_nxt | hwSet) & MASK; // R08
    end
    // storage with synchronous reset
    always @(posedge clk) begin
        if (!resetn) begin
            val_r <= RESET_VAL & MASK;
        end else begin
            val_r <= val_nxt;
        end
    end
endmodule

// *** src/rfa_bank.v ***
// register bank showing each software access policy behind a generic port
//
// Notes on behaviour
// R01: read-to-clear returns value, then clears itself
// R02: software writes reset value into read-only
// R03: any write clears the write-to-clear register
// R04: write one clears bit, zero keeps it
// R05: writing back read status clears only those
// R06: write-only clear: ones clear, reads meaningless
// R07: write one sets bit, zero keeps it
// R08: reserved bits read as zero
// R09: software preserves reserved bits on read-modify-write
// R10: address equals module base plus offset
// R11: read/write field stores and returns written value
`timescale 1ns/1ps
module rfa_bank (
    input wire clk,
    input wire resetn,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regAddr,
    input wire [31:0] regWdata,
    input wire [7:0] hwStatus,
    input wire [15:0] hwCount,
    input wire [7:0] hwEvent,
    output reg [31:0] regRdata,
    output reg regErr,
    output reg [15:0] ctrlOut
);
`include "rfa_regs.vh"
    ////////////////////////////////////////////////////////////////////////
    // decode
    // map, byte offsets from the module base:
    //   0x000 control, read/write, bits 15:0
    //   0x004 status, cleared by its own read, bits 7:0
    //   0x008 event count, any write clears, bits 15:0
    //   0x00c interrupt status, write one to clear, bits 7:0
    //   0x010 interrupt clear, write only, bits 7:0
    //   0x014 flags, write one to set, bits 7:0
    //   0x018 identity, read only, bits 15:0
    //   0x01c live event lines, read only, bits 7:0
    // any other or misaligned address answers with regErr
    // offset decode from base, unmatched or misaligned yields 7, the last slot
    function [2:0] rfaSel;
        input [31:0] addr;
        reg [31:0] off;
        begin
            off = addr - `RFA_BASE; // R10
            rfaSel = 3'h7;
            if (off[31:12] == 20'h00000 && off[1:0] == 2'h0 && off[11:5] == 7'h00) begin
                rfaSel = off[4:2];
            end
        end
    endfunction
    wire [2:0] sel;
    wire hit;
    wire [7:0] wrSel;
    wire [7:0] rdSel;
    // hit and sel must agree: sel alone lands stray addresses on the last slot
    assign sel = rfaSel(regAddr);
    assign hit = (regAddr - `RFA_BASE) < 32'h00000020 && regAddr[1:0] == 2'h0;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gSel
            assign wrSel[g] = regWr && hit && (sel == g);
            assign rdSel[g] = regRd && hit && (sel == g);
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // hardware inputs pass two flops before use
    // the third event flop only feeds the edge detector, never the cells
    reg [7:0] stat1_r;
    reg [7:0] stat2_r;
    reg [15:0] cnt1_r;
    reg [15:0] cnt2_r;
    reg [7:0] evt1_r;
    reg [7:0] evt2_r;
    reg [7:0] evt3_r;
    always @(posedge clk) begin
        if (!resetn) begin
            stat1_r <= 8'h00;
            stat2_r <= 8'h00;
            cnt1_r <= 16'h0000;
            cnt2_r <= 16'h0000;
            evt1_r <= 8'h00;
            evt2_r <= 8'h00;
            evt3_r <= 8'h00;
        end else begin
            stat1_r <= hwStatus;
            stat2_r <= stat1_r;
            cnt1_r <= hwCount;
            cnt2_r <= cnt1_r;
            evt1_r <= hwEvent;
            evt2_r <= evt1_r;
            evt3_r <= evt2_r;
        end
    end
    // rising edge of each synchronised event line
    wire [7:0] evtPulse;
    assign evtPulse = evt2_r & ~evt3_r;
    ////////////////////////////////////////////////////////////////////////
    // policy cells
    wire [31:0] ctrlVal;
    wire [31:0] rcVal;
    wire [31:0] rwcVal;
    wire [31:0] isrVal;
    wire [31:0] iclrVal;
    wire [31:0] setVal;
    wire [31:0] isrPend;
    // plain read/write control steering ctrlOut
    rfa_field #(
        .POLICY(`RFA_POL_RW),
        .MASK(`RFA_CTRL_MASK),
        .RESET_VAL(`RFA_CTRL_RST)
    ) uCtrl (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[0]),
        .rdEn(rdSel[0]),
        .wrData(regWdata),
        .hwSet(32'h00000000),
        .value(ctrlVal)
    ); // R11
    // read-to-clear status latching synchronised status highs
    rfa_field #(
        .POLICY(`RFA_POL_RC),
        .MASK(`RFA_STAT_MASK),
        .RESET_VAL(32'h00000000)
    ) uStat (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[1]),
        .rdEn(rdSel[1]),
        .wrData(regWdata),
        .hwSet({24'h000000, stat2_r}),
        .value(rcVal)
    ); // R01
    // write-any-to-clear accumulator of counted events
    rfa_field #(
        .POLICY(`RFA_POL_RWC),
        .MASK(`RFA_RWC_MASK),
        .RESET_VAL(32'h00000000)
    ) uRwc (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[2]),
        .rdEn(rdSel[2]),
        .wrData(regWdata),
        .hwSet({16'h0000, cnt2_r}),
        .value(rwcVal)
    ); // R03
    // readable write-one-to-clear interrupt status
    rfa_field #(
        .POLICY(`RFA_POL_RW1C),
        .MASK(`RFA_ISR_MASK),
        .RESET_VAL(32'h00000000)
    ) uIsr (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[3]),
        .rdEn(rdSel[3]),
        .wrData(regWdata),
        .hwSet({24'h000000, evtPulse}),
        .value(isrVal)
    ); // R04 R05
    // write-only clear port, set by the same events as the status store
    rfa_field #(
        .POLICY(`RFA_POL_W1C),
        .MASK(`RFA_ISR_MASK),
        .RESET_VAL(32'h00000000)
    ) uIclr (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[4]),
        .rdEn(rdSel[4]),
        .wrData(regWdata),
        .hwSet({24'h000000, evtPulse}),
        .value(iclrVal)
    ); // R06
    // write-one-to-set flags
    rfa_field #(
        .POLICY(`RFA_POL_RW1S),
        .MASK(`RFA_SET_MASK),
        .RESET_VAL(32'h00000000)
    ) uSet (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrSel[5]),
        .rdEn(rdSel[5]),
        .wrData(regWdata),
        .hwSet(32'h00000000),
        .value(setVal)
    ); // R07
    // a status bit stays pending only while neither clear path has removed it
    assign isrPend = isrVal & iclrVal; // R06
    ////////////////////////////////////////////////////////////////////////
    // read mux; reserved bits masked to zero
    reg [31:0] rdMux;
    always @* begin
        case (sel)
            3'h0: rdMux = ctrlVal & `RFA_CTRL_MASK;
            3'h1: rdMux = rcVal & `RFA_STAT_MASK; // R01
            3'h2: rdMux = rwcVal & `RFA_RWC_MASK;
            3'h3: rdMux = isrPend & `RFA_ISR_MASK; // R04 R06
            3'h4: rdMux = 32'h00000000; // R06
            3'h5: rdMux = setVal & `RFA_SET_MASK;
            3'h6: rdMux = `RFA_ID_VAL & `RFA_ID_MASK; // R02
            3'h7: rdMux = {24'h000000, evt2_r} & `RFA_EVT_MASK; // R08
            default: rdMux = 32'h00000000;
        endcase
    end
    // registered read data, error flag and control output
    // read data is zero outside a read so a stale value never lingers
    always @(posedge clk) begin
        if (!resetn) begin
            regRdata <= 32'h00000000;
            regErr <= 1'b0;
            ctrlOut <= 16'h0000;
        end else begin
            regRdata <= (regRd && hit) ? rdMux : 32'h00000000; // R08
            regErr <= (regRd || regWr) && !hit;
            ctrlOut <= ctrlVal[15:0];
        end
    end
endmodule

// *** dv/rfa_bank_monitor.sv ***
// concurrent checks on the policy bank ports
`timescale 1ns/1ps
`include "rfa_regs.vh"
module rfa_bank_monitor (
    input wire clk,
    input wire resetn,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regAddr,
    input wire [31:0] regWdata,
    input wire [7:0] hwStatus,
    input wire [15:0] hwCount,
    input wire [7:0] hwEvent,
    input wire [31:0] regRdata,
    input wire regErr,
    input wire [15:0] ctrlOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // field behaviour seen through reads, writes and the control output
    chk_ctrl_copy: assert property (regWr && regAddr == `RFA_BASE |-> ##2 ctrlOut == $past(regWdata[15:0], 2))
        else $error("ctrl copy wrong");
    chk_resv_zero: assert property (regRdata[31:16] == 16'h0)
        else $error("reserved bits set");
    chk_wo_read: assert property (regRd && regAddr == `RFA_BASE + `RFA_OFF_ICLR |=> regRdata == 32'h0)
        else $error("write-only reads data");
    chk_id_read: assert property (regRd && regAddr == `RFA_BASE + `RFA_OFF_ID |=> regRdata == `RFA_ID_VAL)
        else $error("id read wrong");
    // status sources quiet while they could still re-set the cleared cell
    chk_rc_clear: assert property (regRd && regAddr == `RFA_BASE + `RFA_OFF_STAT &&
        $past(hwStatus, 1) == 8'h00 && $past(hwStatus, 2) == 8'h00 ##2
        regRd && regAddr == `RFA_BASE + `RFA_OFF_STAT |=> regRdata[7:0] == 8'h0)
        else $error("status not cleared");
    chk_any_clear: assert property (regWr && regAddr == `RFA_BASE + `RFA_OFF_RWC &&
        $past(hwCount, 1) == 16'h0000 && $past(hwCount, 2) == 16'h0000 ##2
        regRd && regAddr == `RFA_BASE + `RFA_OFF_RWC |=> regRdata == 32'h0)
        else $error("write did not clear");
    chk_one_clear: assert property (regWr && regAddr == `RFA_BASE + `RFA_OFF_ISR &&
        $past(hwEvent, 1) == $past(hwEvent, 2) && $past(hwEvent, 2) == $past(hwEvent, 3) ##2
        regRd && regAddr == `RFA_BASE + `RFA_OFF_ISR |=> (regRdata[7:0] & $past(regWdata[7:0], 3)) == 8'h0)
        else $error("one did not clear");
    chk_one_set: assert property (regWr && regAddr == `RFA_BASE + `RFA_OFF_SET ##2
        regRd && regAddr == `RFA_BASE + `RFA_OFF_SET |=> ($past(regWdata[7:0], 3) & ~regRdata[7:0]) == 8'h0)
        else $error("one did not set");
    // main scenarios reached
    cov_err: cover property (regErr);
    cov_isr: cover property (regRd && regAddr == `RFA_BASE + `RFA_OFF_ISR ##1 regRdata != 32'h0);
    cov_ctrl: cover property (regWr && regAddr == `RFA_BASE);
endmodule
bind rfa_bank rfa_bank_monitor u_rfa_bank_monitor (.clk(clk), .resetn(resetn), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .hwStatus(hwStatus), .hwCount(hwCount), .hwEvent(hwEvent),
    .regRdata(regRdata), .regErr(regErr), .ctrlOut(ctrlOut));

// *** dv/rfa_bank_tb.sv ***
// self-checking bench for the policy bank
`timescale 1ns/1ps
`include "rfa_regs.vh"
module rfa_bank_tb;
    reg clk, resetn, regWr, regRd;
    reg [31:0] regAddr, regWdata, d;
    reg [7:0] hwStatus, hwEvent, setAcc;
    reg [15:0] hwCount;
    wire [31:0] regRdata;
    wire regErr;
    wire [15:0] ctrlOut;
    integer seed = 6, errTotal = 0, testsRun = 0, cyc = 0, i;
    rfa_bank u_rfa_bank (.clk(clk), .resetn(resetn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWdata(regWdata), .hwStatus(hwStatus), .hwCount(hwCount), .hwEvent(hwEvent),
        .regRdata(regRdata), .regErr(regErr), .ctrlOut(ctrlOut));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errTotal = errTotal + 1;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    // helpers: compare, bus cycles, hardware levels, expectation
    function [7:0] w1c(input [7:0] v, input [7:0] w);
        w1c = v & ~w;
    endfunction
    task check(input string nm, input [32:0] exp, input [32:0] got);
        testsRun = testsRun + 1;
        if (got !== exp) begin
            errTotal = errTotal + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input [11:0] off, input [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= `RFA_BASE + off;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input [11:0] off, input [32:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= `RFA_BASE + off;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check("regErr,regRdata", exp, {regErr, regRdata});
    endtask
    task hw(input [7:0] s, input [15:0] c, input [7:0] e);
        @(posedge clk);
        hwStatus <= s;
        hwCount <= c;
        hwEvent <= e;
        repeat (4) @(posedge clk);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {resetn, regWr, regRd, regAddr, regWdata, hwStatus, hwCount, hwEvent, setAcc} = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            d = $random(seed);
            wr(`RFA_OFF_CTRL, d);
            rd(`RFA_OFF_CTRL, {17'h0, d[15:0]});
            check("ctrlOut", {17'h0, d[15:0]}, {17'h0, ctrlOut});
        end
        // read-modify-write: reserved bits go back exactly as they were read
        d = {regRdata[31:16], ~d[15:0]};
        wr(`RFA_OFF_CTRL, d);
        rd(`RFA_OFF_CTRL, {17'h0, d[15:0]});
        check("ctrlOut", {17'h0, d[15:0]}, {17'h0, ctrlOut});
        wr(`RFA_OFF_ID, `RFA_ID_VAL);
        rd(`RFA_OFF_ID, {1'b0, `RFA_ID_VAL});
        rd(`RFA_OFF_ICLR, 33'h0);
        rd(12'h020, 33'h100000000);
        rd(12'h002, 33'h100000000);
        for (i = 0; i < 5; i = i + 1) begin
            d = (i == 4) ? 32'h0 : $random(seed);
            wr(`RFA_OFF_SET, d);
            setAcc = setAcc | d[7:0];
            rd(`RFA_OFF_SET, {25'h0, setAcc});
        end
        hw(8'ha5, 16'h1234, 8'hff);
        hw(8'h00, 16'h0000, 8'hff);
        rd(`RFA_OFF_STAT, 33'ha5);
        rd(`RFA_OFF_STAT, 33'h0);
        rd(`RFA_OFF_RWC, 33'h1234);
        wr(`RFA_OFF_RWC, $random(seed));
        rd(`RFA_OFF_RWC, 33'h0);
        rd(`RFA_OFF_ISR, 33'hff);
        wr(`RFA_OFF_ISR, 32'h0f);
        rd(`RFA_OFF_ISR, {25'h0, w1c(8'hff, 8'h0f)});
        // a new event lands between the read and its write-back
        hw(8'h00, 16'h0000, 8'h00);
        hw(8'h00, 16'h0000, 8'h01);
        rd(`RFA_OFF_EVT, 33'h1);
        wr(`RFA_OFF_ISR, 32'hf0);
        rd(`RFA_OFF_ISR, {25'h0, w1c(8'hf1, 8'hf0)});
        // write-only clear: zeros leave the pending bit, a one removes it
        wr(`RFA_OFF_ICLR, 32'hfe);
        rd(`RFA_OFF_ISR, 33'h1);
        wr(`RFA_OFF_ICLR, 32'h01);
        rd(`RFA_OFF_ISR, 33'h0);
        rd(`RFA_OFF_ICLR, 33'h0);
        stop_test;
    end
endmodule
